/* File: sim/filter_clamp_monitor.sv */
// Port-level assertions for the filter and clamp register block
`timescale 1ns/1ns
`default_nettype none
module filter_clamp_monitor
    import filter_clamp_pkg::*;
(
    input wire logic            mclk,
    input wire logic            rstn,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [3:0]      pstrb,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic            pslverr,
    input wire logic            sample_valid,
    input wire logic            out_valid,
    input wire logic [23:0]     subcarrier_low,
    input wire logic [27:0]     subcarrier_freq,
    input wire filter_setting_t filter_setting
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////
    // Bus steps: setup cycle, then a completed write of one index
    sequence setup_at(logic [7:0] idx);
        psel && !penable && paddr[9:2] == idx;
    endsequence
    sequence wr_done(logic [7:0] idx);
        psel && penable && pready && pwrite && pstrb[0] && paddr[9:2] == idx;
    endsequence

    // Answer comes in the access cycle only, read data idles at zero
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_only_access: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_unmapped_err: assert property (setup_at(8'h80) |=> pready && pslverr)
        else $error("unmapped index not refused");
    // Settings reach the pipeline two edges after the write edge
    a_luma_follows: assert property (wr_done(IDX_SHAPING_FILTER)
        ##0 (pwdata[4:0] != LUMA_NOT_USED)
        |-> ##2 filter_setting.luma_sel == $past(pwdata[4:0], 2))
        else $error("luma select not taken");
    a_chroma_fixed: assert property (wr_done(IDX_SHAPING_FILTER)
        ##0 (pwdata[7:6] != 2'b00)
        |-> ##2 filter_setting.chroma_sel ==
            3'($past(pwdata[7:5], 2) - 3'h1))
        else $error("fixed chroma select wrong");
    a_luma_unused: assert property (
        filter_setting.luma_sel != LUMA_NOT_USED)
        else $error("unused luma code reached pipeline");
    a_comb_never_bad: assert property (
        filter_setting.comb_lines != 2'b11)
        else $error("invalid comb mode reached pipeline");
    a_chroma_auto_live: assert property ($past(rstn, 3) |->
        filter_setting.chroma_sel != 3'h0)
        else $error("chroma select is zero");
    a_fsc_low_tracks: assert property (subcarrier_freq != 28'h0 |->
        subcarrier_freq[23:0] == $past(subcarrier_low))
        else $error("manual subcarrier low part wrong");
    // Skips the release edge, where outputs still come out of reset
    a_valid_delay: assert property (rstn && $past(rstn) && sample_valid
        |=> out_valid)
        else $error("sample strobe lost");
endmodule : filter_clamp_monitor

bind video_decoder_filter_clamp_regs filter_clamp_monitor u_monitor (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .out_valid(out_valid),
    .subcarrier_low(subcarrier_low), .subcarrier_freq(subcarrier_freq),
    .filter_setting(filter_setting));
`default_nettype wire

/* File: sim/tb_video_decoder_filter_clamp_regs.sv */
// Self-checking bench for the filter and clamp register block
`timescale 1ns/1ns
`default_nettype none
module tb_video_decoder_filter_clamp_regs
    import filter_clamp_pkg::*;
;
    logic mclk, rstn, psel, penable, pwrite, pready, pslverr;
    logic sample_valid, clamp_window, video_quality_indication, out_valid;
    logic [11:0]     paddr, luma_raw, chroma_raw, luma_out, chroma_out;
    logic [31:0]     pwdata, prdata;
    logic [3:0]      pstrb;
    logic [7:0]      scaling_factor;
    logic [23:0]     subcarrier_low;
    logic [27:0]     subcarrier_freq;
    filter_setting_t filter_setting;
    int              miscompares, checks_done;

    // Short step counts keep the clamp loop visible in a brief run
    video_decoder_filter_clamp_regs #(.SLOW_CYCLES(8), .MEDIUM_CYCLES(4),
        .FAST_CYCLES(2)) DUT (.mclk(mclk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .clamp_window(clamp_window),
        .luma_raw(luma_raw), .chroma_raw(chroma_raw),
        .video_quality_indication(video_quality_indication),
        .scaling_factor(scaling_factor), .subcarrier_low(subcarrier_low),
        .out_valid(out_valid), .luma_out(luma_out), .chroma_out(chroma_out),
        .filter_setting(filter_setting), .subcarrier_freq(subcarrier_freq));

    // 25 MHz clock
    always #20 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset;
        rstn <= 1'b0;
        repeat (20) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
    endtask : do_reset

    // Let the edge that follows a write land before looking
    task automatic settle;
        @(posedge mclk);
    endtask : settle

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] r,
                       output logic e);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w;
        paddr <= a; pwdata <= {24'h0, d}; pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r; logic e;
        apb(1'b1, a, d, 4'hF, r, e);
        chk({31'h0, e}, 32'h0);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r; logic e;
        apb(1'b0, a, 8'h00, 4'hF, r, e);
        chk({r[31:1], r[0] | e}, exp);
    endtask : rd

    ////////////////////////////////////////////////////////////////////////
    // Reset values, read-back, refusals and a strobe-less write
    task automatic t_regs;
        logic [31:0] r; logic e;
        rd(12'h054, 32'(RST_CLAMP_CONTROL));
        rd(12'h058, 32'(RST_CLAMP_OFFSET_LOW));
        rd(12'h05C, 32'(RST_SHAPING_FILTER));
        rd(12'h064, 32'(RST_COMB_FILTER));
        rd(12'h08C, 32'(RST_SUBCARRIER_TOP));
        chk(32'(filter_setting), 32'h18);
        wr(12'h058, 8'h5A);
        rd(12'h058, 32'h5A);
        apb(1'b1, 12'h058, 8'hA4, 4'h0, r, e);
        rd(12'h058, 32'h5A);
        apb(1'b0, 12'h200, 8'h00, 4'hF, r, e);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 12'h0C0, 8'h00, 4'hF, r, e);
        chk({31'h0, e}, 32'h1);
    endtask : t_regs

    // Every luma code, with a fixed chroma filter alongside
    task automatic t_luma;
        for (int c = 0; c < 32; c++) begin
            wr(12'h05C, {3'b010, 5'(c)});
            settle();
            chk(32'(filter_setting.luma_sel), (c == 30) ? 0 : c);
            chk(32'(filter_setting.chroma_sel), 32'h1);
        end
    endtask : t_luma

    // Every chroma code against every scaling range
    task automatic t_chroma;
        int x;
        for (int s = 0; s < 4; s++) begin
            scaling_factor <= {2'(s), 6'h15};
            for (int c = 0; c < 8; c++) begin
                wr(12'h05C, {3'(c), 5'h01});
                settle();
                x = (c >= 2) ? c - 1 : ((c == 1) ? 6 : 3) - s;
                chk(32'(filter_setting.chroma_sel), (x < 1) ? 1 : x);
            end
        end
    endtask : t_chroma

    // Comb modes with both adaptivity settings; reserved bits kept zero
    task automatic t_comb;
        for (int m = 0; m < 8; m++) begin
            wr(12'h064, {3'b000, 1'(m >> 2), 2'(m), 2'b00});
            settle();
            chk(32'(filter_setting.comb_lines),
                (m % 4 == 3) ? 0 : m % 4);
            chk(32'(filter_setting.comb_adaptive), m >> 2);
        end
    endtask : t_comb

    task automatic t_subcarrier;
        subcarrier_low <= 24'h5C3A91;
        wr(12'h08C, 8'hF9);
        settle();
        chk(32'(subcarrier_freq), 32'h095C3A91);
        wr(12'h08C, 8'hE9);
        settle();
        chk(32'(subcarrier_freq), 32'(STANDARD_FSC));
    endtask : t_subcarrier

    // Offset applied to chroma in manual mode only; loop idle here
    task automatic t_off(input logic [7:0] ctl, input logic [7:0] low,
                         input logic [11:0] raw, input logic [11:0] exp);
        wr(12'h054, ctl);
        wr(12'h058, low);
        chroma_raw <= raw;
        settle();
        settle();
        chk(32'(chroma_out), 32'(exp));
        chk(32'(luma_out), 32'h345);
    endtask : t_off

    // Freeze holds the loop; fast timing moves it more than slow
    task automatic t_loop;
        logic [31:0] r; logic e;
        int fast, slow, qual;
        clamp_window <= 1'b0;
        luma_raw <= 12'h200;
        wr(12'h054, 8'h10);
        clamp_window <= 1'b1;
        repeat (40) @(posedge mclk);
        chk(32'(luma_out), 32'h200);
        apb(1'b0, 12'h0C0, 8'h00, 4'hF, r, e);
        chk(r & 32'h11FFF, 32'h10000);
        wr(12'h054, 8'h40);
        repeat (40) @(posedge mclk);
        apb(1'b0, 12'h0C0, 8'h00, 4'hF, r, e);
        fast = -int'($signed(r[12:0]));
        do_reset();
        repeat (40) @(posedge mclk);
        apb(1'b0, 12'h0C0, 8'h00, 4'hF, r, e);
        slow = -int'($signed(r[12:0]));
        chk(32'(slow > 0), 32'h1);
        chk(32'(fast > slow), 32'h1);
        // Good video on code 11 keeps the slow rate
        do_reset();
        video_quality_indication <= 1'b1;
        wr(12'h054, 8'h60);
        repeat (40) @(posedge mclk);
        apb(1'b0, 12'h0C0, 8'h00, 4'hF, r, e);
        qual = -int'($signed(r[12:0]));
        chk(32'(2 * qual < fast), 32'h1);
    endtask : t_loop

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        mclk = 0; rstn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hF;
        sample_valid = 0; clamp_window = 0; video_quality_indication = 0;
        luma_raw = 12'h345; chroma_raw = 12'h100; scaling_factor = 8'h00;
        subcarrier_low = 24'h000000;
        miscompares = 0; checks_done = 0;
        do_reset();
        t_regs();
        t_luma();
        t_chroma();
        t_comb();
        t_subcarrier();
        sample_valid <= 1'b1;
        t_off(8'h00, 8'h10, 12'h100, 12'h100);
        t_off(8'h80, 8'h10, 12'h100, 12'h110);
        t_off(8'h81, 8'h10, 12'h100, 12'h210);
        t_off(8'h80, 8'h20, 12'hFF0, 12'hFFF);
        t_off(8'h88, 8'h00, 12'h100, 12'h000);
        t_loop();
        wrap_up();
    end

    // Watchdog: the whole run needs well under this many cycles
    initial begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        wrap_up();
    end
endmodule : tb_video_decoder_filter_clamp_regs
`default_nettype wire

/* File: src/filter_clamp_pkg.sv */
// Package for the filter and clamp configuration register group
package filter_clamp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CLAMP_CONTROL        = 8'h15;
    localparam logic [7:0]  IDX_CLAMP_OFFSET_LOW     = 8'h16;
    localparam logic [7:0]  IDX_SHAPING_FILTER       = 8'h17;
    localparam logic [7:0]  IDX_COMB_FILTER          = 8'h19;
    localparam logic [7:0]  IDX_SUBCARRIER_TOP       = 8'h23;
    localparam logic [7:0]  IDX_CLAMP_STATUS         = 8'h30;

    // Reset values
    localparam logic [7:0]  RST_CLAMP_CONTROL        = 8'h00;
    localparam logic [7:0]  RST_CLAMP_OFFSET_LOW     = 8'h00;
    localparam logic [7:0]  RST_SHAPING_FILTER       = 8'h00;
    localparam logic [7:0]  RST_COMB_FILTER          = 8'h00;
    localparam logic [7:0]  RST_SUBCARRIER_TOP       = 8'hE0;

    // Field layouts, most significant field first
    typedef struct packed {
        logic        manual;
        logic [1:0]  time_sel;
        logic        freeze;
        logic [3:0]  offset_high;
    } clamp_control_t;

    typedef struct packed {
        logic [2:0]  chroma_mode;
        logic [4:0]  luma_mode;
    } shaping_filter_t;

    typedef struct packed {
        logic [2:0]  reserved_high;
        logic        adaptive;
        logic [1:0]  mode;
        logic [1:0]  reserved_low;
    } comb_filter_t;

    typedef struct packed {
        logic [2:0]  reserved_high;
        logic        manual;
        logic [3:0]  freq_top;
    } subcarrier_top_t;

    // Settings presented to the pipeline
    typedef struct packed {
        logic [4:0]  luma_sel;
        logic [2:0]  chroma_sel;
        logic [1:0]  comb_lines;
        logic        comb_adaptive;
    } filter_setting_t;

    typedef enum logic [1:0] {
        COMB_NONE    = 2'b00,
        COMB_ONE     = 2'b01,
        COMB_TWO     = 2'b10,
        COMB_INVALID = 2'b11
    } comb_mode_t;

    typedef enum logic [1:0] {
        TC_SLOW    = 2'b00,
        TC_MEDIUM  = 2'b01,
        TC_FAST    = 2'b10,
        TC_QUALITY = 2'b11
    } clamp_time_t;

    localparam logic [4:0]  LUMA_AUTO_WIDE    = 5'h00;
    localparam logic [4:0]  LUMA_NOT_USED     = 5'h1E;
    localparam logic [2:0]  CHROMA_AUTO_15    = 3'h0;
    localparam logic [2:0]  CHROMA_AUTO_217   = 3'h1;
    localparam logic [2:0]  CHROMA_FIXED_BASE = 3'h1;
    localparam logic [2:0]  CHROMA_BASE_15    = 3'h3;
    localparam logic [2:0]  CHROMA_BASE_217   = 3'h6;
    localparam logic [2:0]  CHROMA_FIRST      = 3'h1;

    // Clamp loop timing
    localparam int          CLOCK_HZ          = 25_000_000;
    localparam int          TC_SLOW_MS        = 1000;
    localparam int          TC_MEDIUM_MS      = 500;
    localparam int          TC_FAST_MS        = 100;
    localparam int          CLAMP_STEPS       = 4096;
    localparam int          SLOW_STEP_CYCLES  =
        (TC_SLOW_MS * (CLOCK_HZ / 1000)) / CLAMP_STEPS;
    localparam int          MEDIUM_STEP_CYCLES =
        (TC_MEDIUM_MS * (CLOCK_HZ / 1000)) / CLAMP_STEPS;
    localparam int          FAST_STEP_CYCLES  =
        (TC_FAST_MS * (CLOCK_HZ / 1000)) / CLAMP_STEPS;

    localparam logic [11:0] BLACK_LEVEL       = 12'h100;
    localparam logic [11:0] SAMPLE_MAX        = 12'hFFF;
    localparam logic [27:0] STANDARD_FSC      = 28'h0000000;

endpackage : filter_clamp_pkg

/* File: src/video_decoder_filter_clamp_regs.sv */
// Filter and clamp configuration registers with the clamp datapath
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Low offset byte held in own register; full offset added to chroma samples
// - Upper four offset bits sit above the low byte
// - Programmed offset used only in manual clamp mode
// - Manual offset correction acts on chroma only, luma untouched
// - Freeze holds the clamp loop correction until cleared
// - Two-bit field sets the clamp loop time constant
// - Five-bit field picks the luma shaping filter; code 11110 unused
// - Three-bit field picks chroma filter: two auto codes, six fixed
// - Auto chroma codes choose the filter from the scaling factor
// - Two-bit comb mode and a separate adaptive bit run the comb
// - Manual bit selects user 28-bit subcarrier or standard frequency
// - Timing codes give 1 s, 0.5 s, 0.1 s, or follow quality
// - Clamp mode bit: 0 automatic, 1 manual offset correction
module video_decoder_filter_clamp_regs
    import filter_clamp_pkg::*;
#(
    parameter int SLOW_CYCLES   = SLOW_STEP_CYCLES,
    parameter int MEDIUM_CYCLES = MEDIUM_STEP_CYCLES,
    parameter int FAST_CYCLES   = FAST_STEP_CYCLES
) (
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          sample_valid,
    input  wire logic          clamp_window,
    input  wire logic [11:0]   luma_raw,
    input  wire logic [11:0]   chroma_raw,
    input  wire logic          video_quality_indication,
    input  wire logic [7:0]    scaling_factor,
    input  wire logic [23:0]   subcarrier_low,
    output logic               out_valid,
    output logic      [11:0]   luma_out,
    output logic      [11:0]   chroma_out,
    output filter_setting_t    filter_setting,
    output logic      [27:0]   subcarrier_freq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Add a signed correction and saturate to the sample range
    function automatic logic [11:0] sat_add(input logic [11:0] sample,
                                            input logic [12:0] corr);
        logic [13:0] sum;
        sum = {2'b00, sample} + {corr[12], corr};
        if (sum[13]) begin
            sat_add = 12'h000;
        end else if (sum[12]) begin
            sat_add = SAMPLE_MAX;
        end else begin
            sat_add = sum[11:0];
        end
    endfunction : sat_add

    // Word index of an APB byte address
    function automatic logic [7:0] word_index(input logic [11:0] addr);
        word_index = addr[9:2];
    endfunction : word_index

    ////////////////////////////////////////////////////////////////////////
    // Register state

    clamp_control_t    clamp_control;
    logic [7:0]        clamp_offset_low;
    shaping_filter_t   shaping_filter_control;
    comb_filter_t      comb_filter_control;
    subcarrier_top_t   subcarrier_control_top;
    clamp_control_t    next_clamp_control;
    logic [7:0]        next_clamp_offset_low;
    shaping_filter_t   next_shaping_filter_control;
    comb_filter_t      next_comb_filter_control;
    subcarrier_top_t   next_subcarrier_control_top;
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;

    logic [12:0]       clamp_corr;
    logic [7:0]        idx;
    logic              access;
    logic              wr_en;
    logic              mapped;

    assign idx    = word_index(paddr);
    assign access = psel && penable && pready;
    assign wr_en  = access && pwrite && pstrb[0] && !pslverr;

    // Decode, write and read data; one wait-free access phase per transfer
    always_comb begin
        next_clamp_control          = clamp_control;
        next_clamp_offset_low       = clamp_offset_low;
        next_shaping_filter_control = shaping_filter_control;
        next_comb_filter_control    = comb_filter_control;
        next_subcarrier_control_top = subcarrier_control_top;
        next_prdata                 = 32'h00000000;
        mapped                      = 1'b1;
        case (idx)
            IDX_CLAMP_CONTROL: begin
                next_prdata[7:0] = clamp_control;
            end
            IDX_CLAMP_OFFSET_LOW: begin
                next_prdata[7:0] = clamp_offset_low;
            end
            IDX_SHAPING_FILTER: begin
                next_prdata[7:0] = shaping_filter_control;
            end
            IDX_COMB_FILTER: begin
                next_prdata[7:0] = comb_filter_control;
            end
            IDX_SUBCARRIER_TOP: begin
                next_prdata[7:0] = subcarrier_control_top;
            end
            IDX_CLAMP_STATUS: begin
                next_prdata[12:0] = clamp_corr;
                next_prdata[16]   = clamp_control.freeze;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        // Status is read-only, so a write to it is refused
        if (psel && pwrite && idx == IDX_CLAMP_STATUS) begin
            mapped = 1'b0;
        end
        if (wr_en) begin
            case (idx)
                IDX_CLAMP_CONTROL: begin
                    next_clamp_control = pwdata[7:0];
                end
                IDX_CLAMP_OFFSET_LOW: begin
                    next_clamp_offset_low = pwdata[7:0];
                end
                IDX_SHAPING_FILTER: begin
                    next_shaping_filter_control = pwdata[7:0];
                end
                IDX_COMB_FILTER: begin
                    next_comb_filter_control = pwdata[7:0];
                end
                IDX_SUBCARRIER_TOP: begin
                    next_subcarrier_control_top = pwdata[7:0];
                end
                default: begin
                    next_clamp_control = clamp_control;
                end
            endcase
        end
        // Ready rises in the access phase that follows each setup cycle
        next_pready  = psel && !penable;
        next_pslverr = psel && !penable && !mapped;
        if (!(psel && !penable) || pwrite) begin
            next_prdata = 32'h00000000;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            clamp_control          <= RST_CLAMP_CONTROL;
            clamp_offset_low       <= RST_CLAMP_OFFSET_LOW;
            shaping_filter_control <= RST_SHAPING_FILTER;
            comb_filter_control    <= RST_COMB_FILTER;
            subcarrier_control_top <= RST_SUBCARRIER_TOP;
            prdata                 <= 32'h00000000;
            pready                 <= 1'b0;
            pslverr                <= 1'b0;
        end else begin
            clamp_control          <= next_clamp_control;
            clamp_offset_low       <= next_clamp_offset_low;
            shaping_filter_control <= next_shaping_filter_control;
            comb_filter_control    <= next_comb_filter_control;
            subcarrier_control_top <= next_subcarrier_control_top;
            prdata                 <= next_prdata;
            pready                 <= next_pready;
            pslverr                <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Digital clamp loop

    logic [15:0]       step_count;
    logic [15:0]       next_step_count;
    logic [12:0]       next_clamp_corr;
    logic [15:0]       step_limit;
    logic [11:0]       luma_clamped;
    logic              step_tick;

    // Step interval picks the loop time constant
    always_comb begin
        case (clamp_time_t'(clamp_control.time_sel))
            TC_SLOW: begin
                step_limit = 16'(SLOW_CYCLES - 1);
            end
            TC_MEDIUM: begin
                step_limit = 16'(MEDIUM_CYCLES - 1);
            end
            TC_FAST: begin
                step_limit = 16'(FAST_CYCLES - 1);
            end
            default: begin
                // Good video settles slowly, poor video tracks fast
                step_limit = video_quality_indication ?
                             16'(SLOW_CYCLES - 1) :
                             16'(FAST_CYCLES - 1);
            end
        endcase
    end

    assign step_tick    = (step_count >= step_limit);
    assign luma_clamped = sat_add(luma_raw, clamp_corr);

    // Loop nudges luma black level toward target once per step
    always_comb begin
        next_step_count = step_count;
        next_clamp_corr = clamp_corr;
        if (!clamp_control.freeze) begin
            next_step_count = step_tick ? 16'h0000 : step_count + 16'h0001;
            if (step_tick && sample_valid && clamp_window) begin
                if (luma_clamped > BLACK_LEVEL) begin
                    next_clamp_corr = clamp_corr - 13'h0001;
                end else if (luma_clamped < BLACK_LEVEL) begin
                    next_clamp_corr = clamp_corr + 13'h0001;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            step_count <= 16'h0000;
            clamp_corr <= 13'h0000;
        end else begin
            step_count <= next_step_count;
            clamp_corr <= next_clamp_corr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample correction

    logic [11:0]       offset_value;
    logic [12:0]       chroma_corr;
    logic [11:0]       next_luma_out;
    logic [11:0]       next_chroma_out;
    logic              next_out_valid;

    // Twelve-bit offset, treated as two's complement
    assign offset_value = {clamp_control.offset_high,
                           clamp_offset_low};

    // Manual mode swaps the chroma loop term for the programmed offset
    always_comb begin
        if (clamp_control.manual) begin
            chroma_corr = {offset_value[11], offset_value};
        end else begin
            chroma_corr = clamp_corr;
        end
        next_luma_out   = luma_clamped;
        next_chroma_out = sat_add(chroma_raw, chroma_corr);
        next_out_valid  = sample_valid;
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            luma_out   <= 12'h000;
            chroma_out <= 12'h000;
            out_valid  <= 1'b0;
        end else begin
            luma_out   <= next_luma_out;
            chroma_out <= next_chroma_out;
            out_valid  <= next_out_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Filter and subcarrier selection

    filter_setting_t   next_filter_setting;
    logic [27:0]       next_subcarrier_freq;
    logic [2:0]        chroma_base;
    logic [2:0]        chroma_drop;

    // Resolve auto chroma codes and invalid codes into plain selections
    always_comb begin
        next_filter_setting = filter_setting;
        // Unused luma code falls back to auto wide notch
        if (shaping_filter_control.luma_mode == LUMA_NOT_USED) begin
            next_filter_setting.luma_sel = LUMA_AUTO_WIDE;
        end else begin
            next_filter_setting.luma_sel =
                shaping_filter_control.luma_mode;
        end
        chroma_base = (shaping_filter_control.chroma_mode == CHROMA_AUTO_15) ?
                      CHROMA_BASE_15 : CHROMA_BASE_217;
        // Stronger downscaling picks a narrower filter
        chroma_drop = {1'b0, scaling_factor[7:6]};
        if (shaping_filter_control.chroma_mode <= CHROMA_AUTO_217) begin
            next_filter_setting.chroma_sel =
                (chroma_base > chroma_drop + CHROMA_FIRST) ?
                chroma_base - chroma_drop : CHROMA_FIRST;
        end else begin
            next_filter_setting.chroma_sel =
                shaping_filter_control.chroma_mode -
                CHROMA_FIXED_BASE;
        end
        // Invalid comb code is run as no comb rather than guessed
        if (comb_mode_t'(comb_filter_control.mode) == COMB_INVALID) begin
            next_filter_setting.comb_lines = COMB_NONE;
        end else begin
            next_filter_setting.comb_lines = comb_filter_control.mode;
        end
        next_filter_setting.comb_adaptive =
            comb_filter_control.adaptive;
        if (subcarrier_control_top.manual) begin
            next_subcarrier_freq = {subcarrier_control_top.freq_top,
                                    subcarrier_low};
        end else begin
            next_subcarrier_freq = STANDARD_FSC;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            filter_setting  <= '0;
            subcarrier_freq <= 28'h0000000;
        end else begin
            filter_setting  <= next_filter_setting;
            subcarrier_freq <= next_subcarrier_freq;
        end
    end

endmodule : video_decoder_filter_clamp_regs

`default_nettype wire
